// ---- shared/dtc_pkg.sv ----
// Constants, register map and state type for the drive terminal logic
package dtc_pkg;

  // Time base: 125 MHz logic clock, one millisecond tick
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DECEL  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Control register field positions
  localparam int CTRL_SENSE   = 0;
  localparam int CTRL_PID_LO  = 1;
  localparam int CTRL_PID_HI  = 2;
  localparam int CTRL_ANALOG  = 3;
  localparam int CTRL_RMODE_LO = 4;
  localparam int CTRL_RMODE_HI = 6;

  // Status register field positions
  localparam int STAT_STATE_LO = 0;
  localparam int STAT_STATE_HI = 2;
  localparam int STAT_OUT_ON   = 3;
  localparam int STAT_STOP_ALM = 4;
  localparam int STAT_MONITOR  = 5;
  localparam int STAT_INVERSE  = 6;
  localparam int STAT_PID_ON   = 7;
  localparam int STAT_LINE     = 8;

  // Values after reset
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0008;
  localparam logic [15:0] DECEL_RESET = 16'h0064;

  // PID mode encodings
  localparam logic [1:0] PID_OFF     = 2'h0;
  localparam logic [1:0] PID_NORMAL  = 2'h1;
  localparam logic [1:0] PID_INVERSE = 2'h2;

  // Line frequencies in hertz
  localparam logic [7:0] LINE_HZ_50 = 8'h32;
  localparam logic [7:0] LINE_HZ_60 = 8'h3C;

  // Drive sequencing states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LINE  = 3'b001,
    ST_NORM  = 3'b010,
    ST_INHIB = 3'b011,
    ST_FSTOP = 3'b100,
    ST_TRIP  = 3'b101
  } dtc_state_t;

endpackage

// ---- shared/dtc_tmr_if.sv ----
// Interface between the sequencer and its millisecond timer
`timescale 1ns/1ps
interface dtc_tmr_if;
  logic        ce;
  logic        load;
  logic [15:0] loadMs;
  logic        done;
  modport ctrl  (output ce, output load, output loadMs, input done);
  modport timer (input ce, input load, input loadMs, output done);
endinterface // dtc_tmr_if

// ---- core/dtc_ms_timer.sv ----
// Millisecond down-counter used for the forced-stop deceleration
`timescale 1ns/1ps
module dtc_ms_timer #(
  parameter int TICK_CYCLES = dtc_pkg::TICK_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset_n,
  dtc_tmr_if.timer  tmr
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  logic [PW-1:0] tickCnt_reg;
  logic [15:0]   msLeft_reg;
  logic          armed_reg;
  logic          done_reg;
  wire           tick;

  // Fixed millisecond tick from the logic clock
  assign tick     = (tickCnt_reg == PW'(TICK_CYCLES - 1));
  assign tmr.done = done_reg;

  //////////////////////////////////////////////////////////////////////////
  // Prescaler restarts on load so the first interval is a whole ms
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_reg <= '0;
    end else if (tmr.ce) begin
      if (tmr.load || tick) begin
        tickCnt_reg <= '0;
      end else begin
        tickCnt_reg <= tickCnt_reg + PW'(1);
      end
    end
  end

  // Count down whole ms; done holds until the next load
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      msLeft_reg <= 16'h0000;
      armed_reg  <= 1'b0;
      done_reg   <= 1'b0;
    end else if (tmr.ce) begin
      if (tmr.load) begin
        msLeft_reg <= tmr.loadMs;
        armed_reg  <= 1'b1;
        done_reg   <= 1'b0;
      end else if (armed_reg && msLeft_reg == 16'h0000) begin
        armed_reg <= 1'b0;
        done_reg  <= 1'b1;
      end else if (armed_reg && tick) begin
        msLeft_reg <= msLeft_reg - 16'h0001;
      end
    end
  end

endmodule // dtc_ms_timer

// ---- core/dtc_terminal_logic.sv ----
// Terminal command sequencer for line handover, PID and forced stop
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
//
// Operation
// - Handover plus run starts at line frequency
// - Alarm or coast at handover keeps output off
// - After inhibit, start from ordinary starting frequency
// - PID cancel selects manual reference, else PID
// - Without PID, inverse select only touches analog primary source
// - Analog sense is parameter XOR inverse select
// - PID sense is mode inverted by select
// - With PID cancelled, sense parameter alone
// - Universal input is monitored, never acts
// - Forced stop decelerates, then stop alarm
// - Coast shuts output at once, no alarm
module dtc_terminal_logic #(
  parameter int TICK_CYCLES = dtc_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clockEnable,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        runCommand,
  input  wire logic        lineHandover50hz,
  input  wire logic        lineHandover60hz,
  input  wire logic        coastCommand,
  input  wire logic        forcedStopN,
  input  wire logic        alarmPending,
  input  wire logic        alarmReset,
  input  wire logic        pidCancel,
  input  wire logic        inverseSelect,
  input  wire logic        universalMonitorInput,
  output logic             outputOn,
  output logic             lineFreqStart,
  output logic      [7:0]  lineFreqHz,
  output logic             pidEnable,
  output logic             finalInverse,
  output logic             forcedDecel,
  output logic             stopAlarm
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  dtc_pkg::dtc_state_t state_reg;
  dtc_pkg::dtc_state_t stateNext;

  logic        sense_reg;
  logic [1:0]  pidMode_reg;
  logic        primaryAnalog_reg;
  logic [2:0]  restartMode_reg;
  logic [15:0] decelMs_reg;
  logic        monitor_reg;

  logic        outputOn_reg;
  logic        lineStart_reg;
  logic [7:0]  lineHz_reg;
  logic        pidEnable_reg;
  logic        finalInverse_reg;
  logic        forcedDecel_reg;
  logic        stopAlarm_reg;

  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  logic        tmrLoad;

  dtc_tmr_if tmrBus ();

  //////////////////////////////////////////////////////////////////////////
  // Timer hookup
  assign tmrBus.ce     = clockEnable;
  assign tmrBus.load   = tmrLoad;
  assign tmrBus.loadMs = decelMs_reg;

  dtc_ms_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) uTimer (
    .clock   (clock),
    .reset_n (reset_n),
    .tmr     (tmrBus.timer)
  );

  //////////////////////////////////////////////////////////////////////////
  // Command decoding
  // Inputs are synchronous to the clock, used as sampled
  wire handover  = lineHandover50hz | lineHandover60hz;
  wire blocked   = coastCommand | alarmPending;
  wire startReq  = runCommand & forcedStopN;
  wire tmrDone   = tmrBus.done;
  wire running   = (state_reg == dtc_pkg::ST_LINE) ||
                   (state_reg == dtc_pkg::ST_NORM);

  // Both assigned is illegal; if seen, 60 Hz wins
  wire [7:0] handoverHz = lineHandover60hz ? dtc_pkg::LINE_HZ_60
                                           : dtc_pkg::LINE_HZ_50;

  // Direction of action for the frequency reference
  wire pidModeOn  = (pidMode_reg != dtc_pkg::PID_OFF);
  wire pidOn      = pidModeOn & ~pidCancel;
  wire pidSense   = (pidMode_reg == dtc_pkg::PID_INVERSE)
                    ^ inverseSelect;
  wire analogSns  = sense_reg
                    ^ (inverseSelect & primaryAnalog_reg);
  wire manualSns  = pidModeOn ? sense_reg : analogSns;
  wire inverseNxt = pidOn ? pidSense : manualSns;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  // Stop from run is shown as idle; ramp-down is outside this block
  always_comb begin
    stateNext = state_reg;
    tmrLoad   = 1'b0;
    unique case (state_reg)
      dtc_pkg::ST_IDLE: begin
        if (startReq && blocked && handover) begin
          stateNext = dtc_pkg::ST_INHIB;
        end else if (startReq && !blocked && handover) begin
          stateNext = dtc_pkg::ST_LINE;
        end else if (startReq && !blocked) begin
          stateNext = dtc_pkg::ST_NORM;
        end
      end
      dtc_pkg::ST_INHIB: begin
        if (!runCommand) begin
          stateNext = dtc_pkg::ST_IDLE;
        end else if (startReq && !blocked) begin
          stateNext = dtc_pkg::ST_NORM;
        end
      end
      dtc_pkg::ST_LINE, dtc_pkg::ST_NORM: begin
        if (blocked) begin
          stateNext = dtc_pkg::ST_IDLE;
        end else if (!forcedStopN) begin
          stateNext = dtc_pkg::ST_FSTOP;
          tmrLoad   = 1'b1;
        end else if (!runCommand) begin
          stateNext = dtc_pkg::ST_IDLE;
        end else if (!handover) begin
          stateNext = dtc_pkg::ST_NORM;
        end
      end
      dtc_pkg::ST_FSTOP: begin
        if (tmrDone) begin
          stateNext = dtc_pkg::ST_TRIP;
        end
      end
      dtc_pkg::ST_TRIP: begin
        if (alarmReset) begin
          stateNext = dtc_pkg::ST_IDLE;
        end
      end
      default: begin
        stateNext = dtc_pkg::ST_IDLE;
      end
    endcase
  end

  // Output levels follow the next state so they change with it
  wire outOnNxt = ((stateNext == dtc_pkg::ST_LINE) ||
                   (stateNext == dtc_pkg::ST_NORM) ||
                   (stateNext == dtc_pkg::ST_FSTOP)) && !coastCommand;
  wire lineNxt  = (stateNext == dtc_pkg::ST_LINE);
  wire lineEdge = lineNxt && (state_reg != dtc_pkg::ST_LINE);

  //////////////////////////////////////////////////////////////////////////
  // Sequencer and drive output registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg        <= dtc_pkg::ST_IDLE;
      outputOn_reg     <= 1'b0;
      lineStart_reg    <= 1'b0;
      lineHz_reg       <= dtc_pkg::LINE_HZ_50;
      pidEnable_reg    <= 1'b0;
      finalInverse_reg <= 1'b0;
      forcedDecel_reg  <= 1'b0;
      stopAlarm_reg    <= 1'b0;
      monitor_reg      <= 1'b0;
    end else if (clockEnable) begin
      state_reg        <= stateNext;
      outputOn_reg     <= outOnNxt;
      lineStart_reg    <= lineNxt;
      lineHz_reg       <= lineEdge ? handoverHz : lineHz_reg;
      pidEnable_reg    <= pidOn;
      finalInverse_reg <= inverseNxt;
      forcedDecel_reg  <= (stateNext == dtc_pkg::ST_FSTOP);
      stopAlarm_reg    <= (stateNext == dtc_pkg::ST_TRIP);
      monitor_reg      <= universalMonitorInput;
    end
  end

  assign outputOn      = outputOn_reg;
  assign lineFreqStart = lineStart_reg;
  assign lineFreqHz    = lineHz_reg;
  assign pidEnable     = pidEnable_reg;
  assign finalInverse  = finalInverse_reg;
  assign forcedDecel   = forcedDecel_reg;
  assign stopAlarm     = stopAlarm_reg;

  //////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, write lands on the completing edge

  wire isCtrl   = (paddr == dtc_pkg::ADDR_CTRL);
  wire isDecel  = (paddr == dtc_pkg::ADDR_DECEL);
  wire isStatus = (paddr == dtc_pkg::ADDR_STATUS);
  wire mapped   = isCtrl | isDecel | isStatus;
  wire apbWait  = psel & penable & ~pready_reg;
  wire apbDone  = psel & penable & pready_reg;
  wire wrCtrl   = apbDone & pwrite & isCtrl;
  wire wrDecel  = apbDone & pwrite & isDecel;

  wire [31:0] ctrlWord = {25'h0, restartMode_reg,
                          primaryAnalog_reg, pidMode_reg, sense_reg};
  wire [31:0] statWord = {23'h0, lineStart_reg, pidEnable_reg,
                          finalInverse_reg, monitor_reg, stopAlarm_reg,
                          outputOn_reg, state_reg};
  wire [31:0] readWord = isCtrl  ? ctrlWord :
                         isDecel ? {16'h0000, decelMs_reg} :
                         isStatus ? statWord : 32'h0000_0000;

  // Bus handshake registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (clockEnable) begin
      pready_reg  <= apbWait;
      pslverr_reg <= apbWait & ~mapped;
      prdata_reg  <= apbWait ? readWord : 32'h0000_0000;
    end
  end

  // Configuration registers; restart mode is stored for software only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sense_reg         <= dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_SENSE];
      pidMode_reg       <= dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_PID_HI:
                                               dtc_pkg::CTRL_PID_LO];
      primaryAnalog_reg <= dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_ANALOG];
      restartMode_reg   <= dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_RMODE_HI:
                                               dtc_pkg::CTRL_RMODE_LO];
      decelMs_reg       <= dtc_pkg::DECEL_RESET;
    end else if (clockEnable) begin
      if (wrCtrl) begin
        sense_reg         <= pwdata[dtc_pkg::CTRL_SENSE];
        pidMode_reg       <= pwdata[dtc_pkg::CTRL_PID_HI:
                                    dtc_pkg::CTRL_PID_LO];
        primaryAnalog_reg <= pwdata[dtc_pkg::CTRL_ANALOG];
        restartMode_reg   <= pwdata[dtc_pkg::CTRL_RMODE_HI:
                                    dtc_pkg::CTRL_RMODE_LO];
      end
      if (wrDecel) begin
        decelMs_reg <= pwdata[15:0];
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_line_req;
    clockEnable && state_reg == dtc_pkg::ST_IDLE && startReq
      && !blocked && handover;
  endsequence

  sequence s_inhib_req;
    clockEnable && state_reg == dtc_pkg::ST_IDLE && startReq
      && blocked && handover;
  endsequence

  sequence s_forced;
    clockEnable && running && !blocked && !forcedStopN;
  endsequence

  // Start at the captured line frequency
  property p_line_start;
    s_line_req |=> outputOn_reg && lineStart_reg
      && lineHz_reg == (($past(lineHandover60hz)) ? dtc_pkg::LINE_HZ_60
                                                  : dtc_pkg::LINE_HZ_50);
  endproperty
  a_line_start: assert property (p_line_start)
    else $error("line start not taken");

  // Inhibited handover keeps the output off
  property p_inhibit;
    s_inhib_req |=> state_reg == dtc_pkg::ST_INHIB && !outputOn_reg;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibited handover drove output");

  // Leaving the inhibit starts ordinarily, not at line frequency
  property p_ordinary;
    clockEnable && state_reg == dtc_pkg::ST_INHIB && startReq && !blocked
      |=> outputOn_reg && !lineStart_reg;
  endproperty
  a_ordinary: assert property (p_ordinary)
    else $error("resume after inhibit used line frequency");

  // PID sense from mode and inverse select
  property p_pid_sense;
    clockEnable && pidModeOn && !pidCancel |=> pidEnable_reg
      && finalInverse_reg == (($past(pidMode_reg) == dtc_pkg::PID_INVERSE)
                              ^ $past(inverseSelect));
  endproperty
  a_pid_sense: assert property (p_pid_sense)
    else $error("pid sense wrong");

  // Cancelled PID follows the sense parameter only
  property p_manual_sense;
    clockEnable && pidModeOn && pidCancel
      |=> !pidEnable_reg && finalInverse_reg == $past(sense_reg);
  endproperty
  a_manual_sense: assert property (p_manual_sense)
    else $error("manual sense affected by inverse select");

  // Analog sense is an exclusive-OR of parameter and select
  property p_analog_sense;
    clockEnable && !pidModeOn |=> finalInverse_reg == ($past(sense_reg)
      ^ ($past(inverseSelect) & $past(primaryAnalog_reg)));
  endproperty
  a_analog_sense: assert property (p_analog_sense)
    else $error("analog sense wrong");

  // Forced stop decelerates and ends in the stop alarm
  property p_forced_stop;
    s_forced |=> forcedDecel_reg && !stopAlarm_reg;
  endproperty
  a_forced_stop: assert property (p_forced_stop)
    else $error("forced stop did not decelerate");

  property p_stop_trip;
    clockEnable && state_reg == dtc_pkg::ST_FSTOP && tmrDone
      |=> stopAlarm_reg && !outputOn_reg && !forcedDecel_reg;
  endproperty
  a_stop_trip: assert property (p_stop_trip)
    else $error("stop alarm not raised");

  // Coast drops the output at once without an alarm
  property p_coast;
    clockEnable && running && coastCommand
      |=> !outputOn_reg && !stopAlarm_reg
          && state_reg == dtc_pkg::ST_IDLE;
  endproperty
  a_coast: assert property (p_coast)
    else $error("coast did not shut output");

endmodule // dtc_terminal_logic

// ---- test/dtc_seq_model.sv ----
// External handover sequence that drives the run and handover terminals
`timescale 1ns/1ps
module dtc_seq_model #(
  parameter int LEAD_CYCLES    = 404,
  parameter int OVERLAP_CYCLES = 804
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic runReq,
  input  wire logic lineReq,
  input  wire logic use60,
  input  wire logic coastReq,
  output logic      runCommand,
  output logic      lineHandover50hz,
  output logic      lineHandover60hz,
  output logic      coastCommand
);
  logic [15:0] holdCnt_reg;
  logic        handoverOn_reg;
  logic        leadDone;
  logic        overlapDone;
  logic        holdOn;
  logic        handoverNext;
  logic        handoverAny;
  logic        runNext;

  ////////////////////////////////////////////////////////////////////////////
  // Lead and overlap are counted in plain bench clock cycles, not millisecond ticks
  assign leadDone    = holdCnt_reg >= 16'(LEAD_CYCLES);
  assign overlapDone = holdCnt_reg >= 16'(LEAD_CYCLES + OVERLAP_CYCLES);
  // Only one handover frequency is ever wired up at a time
  assign lineHandover50hz = handoverOn_reg & !use60;
  assign lineHandover60hz = handoverOn_reg & use60;
  assign coastCommand     = coastReq;
  // Handover may only drop once coast is gone and the overlap has run out
  assign holdOn       = coastReq | !overlapDone;
  assign handoverNext = lineReq | (handoverOn_reg & holdOn);
  // Run waits out the lead whenever a handover is asked for or still on
  assign handoverAny  = lineReq | handoverOn_reg;
  assign runNext      = runReq & (leadDone | !handoverAny);

  // Counter runs from the first cycle the handover stands
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      handoverOn_reg <= 1'b0;
      holdCnt_reg    <= 16'h0000;
      runCommand     <= 1'b0;
    end else begin
      handoverOn_reg <= handoverNext;
      holdCnt_reg    <= !handoverOn_reg ? 16'h0000 :
                        (overlapDone ? holdCnt_reg : holdCnt_reg + 16'h0001);
      runCommand     <= runNext;
    end
  end
endmodule // dtc_seq_model

// ---- test/dtc_terminal_logic_tb.sv ----
// Self-checking bench for the terminal command sequencer
`timescale 1ns/1ps
module dtc_terminal_logic_tb;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lineFreqHz;
  logic [31:0] pwdata, prdata;
  logic        runCommand, ho50, ho60, coastCommand, forcedStopN;
  logic        alarmPending, alarmReset, pidCancel, inverseSelect, monIn;
  logic        outputOn, lineFreqStart, pidEnable, finalInverse;
  logic        forcedDecel, stopAlarm, runReq, lineReq, use60, coastReq, ce;
  int          n_fail, n_tests;

  dtc_terminal_logic #(.TICK_CYCLES(4)) i_dut (
    .clock(clock), .reset_n(reset_n), .clockEnable(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .runCommand(runCommand), .lineHandover50hz(ho50),
    .lineHandover60hz(ho60), .coastCommand(coastCommand),
    .forcedStopN(forcedStopN), .alarmPending(alarmPending),
    .alarmReset(alarmReset), .pidCancel(pidCancel),
    .inverseSelect(inverseSelect), .universalMonitorInput(monIn),
    .outputOn(outputOn), .lineFreqStart(lineFreqStart),
    .lineFreqHz(lineFreqHz), .pidEnable(pidEnable),
    .finalInverse(finalInverse), .forcedDecel(forcedDecel),
    .stopAlarm(stopAlarm));

  dtc_seq_model i_part (
    .clock(clock), .reset_n(reset_n), .runReq(runReq), .lineReq(lineReq),
    .use60(use60), .coastReq(coastReq), .runCommand(runCommand),
    .lineHandover50hz(ho50), .lineHandover60hz(ho60),
    .coastCommand(coastCommand));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (i >= 20) begin n_fail++; print_verdict(); end
    @(posedge clock);
  endtask

  // Bounded wait for the external run command
  task automatic waitRun();
    int i;
    for (i = 0; i < 2000 && runCommand !== 1'b1; i++) @(posedge clock);
    if (i >= 2000) begin n_fail++; print_verdict(); end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [31:0] q; logic e;
    apb(dtc_pkg::ADDR_CTRL, 1'b0, 32'h0, q, e);
    check(q, dtc_pkg::CTRL_RESET);
    apb(dtc_pkg::ADDR_DECEL, 1'b0, 32'h0, q, e);
    check(q, {16'h0000, dtc_pkg::DECEL_RESET});
    apb(8'h0C, 1'b0, 32'h0, q, e);
    check({q[30:0], e}, 32'h0000_0001);
    apb(dtc_pkg::ADDR_STATUS, 1'b1, 32'hFFFF_FFFF, q, e);
    apb(dtc_pkg::ADDR_STATUS, 1'b0, 32'h0, q, e);
    check(q, 32'h0000_0000);
    apb(dtc_pkg::ADDR_DECEL, 1'b1, 32'h0000_0003, q, e);
    apb(dtc_pkg::ADDR_DECEL, 1'b0, 32'h0, q, e);
    check(q, 32'h0000_0003);
  endtask

  // Line start at each frequency, output idle during the lead time
  task automatic t_line(input logic u);
    logic [7:0] hz;
    hz = u ? dtc_pkg::LINE_HZ_60 : dtc_pkg::LINE_HZ_50;
    use60 <= u; lineReq <= 1'b1; runReq <= 1'b1;
    cyc(100);
    check(outputOn, 1'b0);
    waitRun();
    cyc(2);
    check({outputOn, lineFreqStart}, 2'b11);
    check(lineFreqHz, hz);
    cyc(810);
    // Handover released first: the drive keeps running on its own
    lineReq <= 1'b0;
    cyc(3);
    check({outputOn, lineFreqStart}, 2'b10);
    // Reference taken as at line frequency before run is handed back
    runReq <= 1'b0;
    cyc(3);
    check(outputOn, 1'b0);
  endtask

  // Handover met by coast or alarm; release then starts normally
  task automatic t_inhib(input logic byAlarm);
    logic [31:0] q; logic e;
    // Restart mode field written but only stored; coast or alarm is held while on line
    apb(dtc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0038, q, e);
    use60 <= 1'b0; lineReq <= 1'b1; runReq <= 1'b1;
    coastReq <= !byAlarm; alarmPending <= byAlarm;
    waitRun();
    cyc(3);
    check({outputOn, lineFreqStart}, 2'b00);
    coastReq <= 1'b0; alarmPending <= 1'b0; alarmReset <= byAlarm;
    cyc(1);
    alarmReset <= 1'b0;
    cyc(3);
    check({outputOn, lineFreqStart}, 2'b10);
    apb(dtc_pkg::ADDR_STATUS, 1'b0, 32'h0, q, e);
    check(q[8], 1'b0);
    runReq <= 1'b0; lineReq <= 1'b0;
    cyc(850);
  endtask

  // Sense table over mode, sense, analog source, cancel and inverse
  task automatic t_sense();
    logic [31:0] q; logic e; logic pe, fi; logic [1:0] m;
    for (int k = 0; k < 48; k++) begin
      m = 2'(k / 16);
      apb(dtc_pkg::ADDR_CTRL, 1'b1, {28'h0, 1'(k >> 1), m, 1'(k)}, q, e);
      pidCancel <= 1'(k >> 2); inverseSelect <= 1'(k >> 3);
      cyc(2);
      pe = m != 2'h0 && !k[2];
      fi = pe ? ((m == 2'h2) ^ k[3]) : (k[0] ^ (k[3] & k[1] & (m == 2'h0)));
      check(pidEnable, pe);
      check(finalInverse, fi);
    end
  endtask

  // Clock enable low freezes the sequencer outputs
  task automatic t_freeze();
    ce <= 1'b0; pidCancel <= 1'b0;
    cyc(3);
    check(pidEnable, 1'b0);
    ce <= 1'b1;
    cyc(2);
    check(pidEnable, 1'b1);
  endtask

  // Monitor input shows in status and moves nothing else
  task automatic t_monitor();
    logic [31:0] q; logic e;
    for (int k = 1; k >= 0; k--) begin
      monIn <= 1'(k);
      cyc(2);
      apb(dtc_pkg::ADDR_STATUS, 1'b0, 32'h0, q, e);
      check(q[5:3], {1'(k), 2'b00});
      check(outputOn, 1'b0);
    end
  endtask

  // Coast while running, then forced stop timed by the decel register
  task automatic t_stop();
    int i;
    runReq <= 1'b1;
    cyc(3);
    check(outputOn, 1'b1);
    coastReq <= 1'b1;
    cyc(2);
    check({outputOn, stopAlarm}, 2'b00);
    coastReq <= 1'b0;
    cyc(3);
    forcedStopN <= 1'b0;
    cyc(2);
    check({forcedDecel, stopAlarm}, 2'b10);
    cyc(8);
    check(stopAlarm, 1'b0);
    for (i = 0; i < 20 && stopAlarm !== 1'b1; i++) @(posedge clock);
    check({stopAlarm, outputOn, forcedDecel}, 3'b100);
    forcedStopN <= 1'b1; runReq <= 1'b0; alarmReset <= 1'b1;
    cyc(2);
    alarmReset <= 1'b0;
    check(stopAlarm, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset and main sequence
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    n_fail = 0; n_tests = 0; reset_n = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; forcedStopN = 1'b1; alarmPending = 1'b0;
    alarmReset = 1'b0; pidCancel = 1'b0; inverseSelect = 1'b0;
    monIn = 1'b0; runReq = 1'b0; lineReq = 1'b0; use60 = 1'b0;
    coastReq = 1'b0; ce = 1'b1;
    cyc(2);
    reset_n <= 1'b1;
    cyc(1);
    t_regs();
    t_line(1'b0);
    t_line(1'b1);
    t_inhib(1'b0);
    t_inhib(1'b1);
    t_sense();
    t_freeze();
    t_monitor();
    t_stop();
    print_verdict();
  end
endmodule // dtc_terminal_logic_tb
